// >>> gts_defs.svh
`ifndef GTS_DEFS_SVH
`define GTS_DEFS_SVH
// ==========================================================
// Address mode codes
`define GTS_ADDRESS_MODE_REGISTER_NOADDR    8'h30
`define GTS_ADDRESS_MODE_REGISTER_TALK_SET  8'hB0
`define GTS_ADDRESS_MODE_REGISTER_LSTN_SET  8'h70
`define GTS_ADDRESS_MODE_REGISTER_TON       8'h80
`define GTS_ADDRESS_MODE_REGISTER_LON       8'h40
// ==========================================================
// Bit positions
`define GTS_INTERRUPT_STATUS_ONE_ERR_BIT   2
`define GTS_INTERRUPT_STATUS_TWO_ADDRESS_STATUS_CHANGE_FLAG_BIT  0
`define GTS_AUXG_NO_TALK_WITHOUT_LISTENER_BIT  3
`define GTS_AUXA_TRANSMIT_END_ON_MATCH_BIT  3
`define GTS_AUXI_ULTRA_SHORT_DELAY_BIT_BIT  3
`define GTS_AUXB_TRI_BIT   2
// ==========================================================
// Timing
`define GTS_CLK_NS         20
`define GTS_T1_2000_NS     2000
`define GTS_T1_1100_NS     1100
`define GTS_T1_500_NS      500
`define GTS_T1_350_NS      350
`define GTS_CYC(ns)        (((ns) + `GTS_CLK_NS - 1) / `GTS_CLK_NS)
`endif

// >>> gts_pkg.sv
package gts_pkg;
  typedef enum logic [2:0] {GTS_IDLE, GTS_SETTLE, GTS_DAV, GTS_WAIT_NDAC} gts_src_e;
  typedef logic [6:0] gts_cnt_t;
endpackage

// >>> gts_talker.sv
`include "gts_defs.svh"
// Summary of operation
// - Hold on talk/listen addresses raises pass-through flag and DAC holdoff.
// - Host writes B0 then 30; device becomes addressed talker.
// - Host writes 70 then 30; device becomes addressed listener.
// - DAC holdoff on captured command lasts until valid command.
// - Hold on all group commands passes through UCG, ACG, SCG.
// - Talk-only or listen-only mode activates function without controller.
// - Active talker exposes live NDAC and NRFD in bus status.
// - No-talk-without-listener bit blocks sourcing when no listener present.
// - Address status change flag sets when addressed state changes.
// - Data-out flag sets once all listeners accepted the byte.
// - Error flag sets when byte pending in talker with no listener present.
// - Interrupt raised on data-out or error when enabled.
// - Discard empties output register while source idle; clear-error clears error flag unless the error condition still holds.
// - Send-end command before write asserts EOI with that byte.
// - Transmit-end-on-match sends END when byte equals end-of-string.
// - DMA request asserted while enabled, talker active and output register empty.
// - Drive byte, wait T1, then assert DAV.
// - Sequence flag clears on ATN, sets after each byte transfer.
// - Primary mode T1 from ultra-short, transmit-rate and sequence flag.
// - Alternate mode T1 from ultra-short, very-short, short and sequence.
// - Pending byte sent after ATN drops unless discarded.
module gts_talker (
  // Clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  // Host configuration
  input  wire logic       ADDRESS_MODE_REGISTER_WR_IN,
  input  wire logic [7:0] ADDRESS_MODE_REGISTER_DATA_IN,
  input  wire logic       HOLD_TALK_ADDR_IN,
  input  wire logic       HOLD_LSTN_ADDR_IN,
  input  wire logic       HOLD_GROUP_IN,
  input  wire logic [7:0] AUX_G_IN,
  input  wire logic [7:0] AUX_A_IN,
  input  wire logic [7:0] AUX_B_IN,
  input  wire logic [7:0] AUX_I_IN,
  input  wire logic       ALT_MODE_IN,
  input  wire logic       VSTD_IN,
  input  wire logic       STD_IN,
  input  wire logic [7:0] EOS_IN,
  input  wire logic       DATA_OUT_IRQ_ENABLE_IN,
  input  wire logic       ERROR_IRQ_ENABLE_IN,
  input  wire logic       DMA_OUT_EN_IN,
  // Host auxiliary command strobes
  input  wire logic       VALID_CMD_IN,
  input  wire logic       DISCARD_CMD_IN,
  input  wire logic       CLEAR_ERR_CMD_IN,
  input  wire logic       SEND_END_CMD_IN,
  input  wire logic       ADDRESS_STATUS_CHANGE_FLAG_CLR_IN,
  input  wire logic       CPT_CLR_IN,
  // Output byte writes, host and DMA
  input  wire logic       OUTPUT_BYTE_REGISTER_WR_IN,
  input  wire logic [7:0] OUTPUT_BYTE_REGISTER_DATA_IN,
  input  wire logic       DMA_ACK_N_IN,
  input  wire logic       DMA_WR_N_IN,
  // Bus pins
  input  wire logic [7:0] DIO_IN,
  input  wire logic       ATN_IN,
  input  wire logic       DAV_IN,
  input  wire logic       NDAC_IN,
  input  wire logic       NRFD_IN,
  output logic      [7:0] DIO_OUT,
  output logic            DIO_OE_OUT,
  output logic            DAV_OUT,
  output logic            EOI_OUT,
  output logic            NDAC_HOLD_OUT,
  // Status
  output logic      [7:0] CAPTURED_COMMAND_REGISTER_OUT,
  output logic            CPT_OUT,
  output logic            TALKER_OUT,
  output logic            LISTENER_OUT,
  output logic            ADDRESS_STATUS_CHANGE_FLAG_OUT,
  output logic            DO_OUT,
  output logic            ERR_OUT,
  output logic      [1:0] BUS_STATUS_OUT,
  output logic            IRQ_OUT,
  output logic            DMA_REQ_OUT,
  output logic            HANDSHAKE_SEQUENCE_FLAG_OUT
);
  // ==========================================================
  // Timing constants
  localparam gts_pkg::gts_cnt_t C2000 = 7'(`GTS_CYC(`GTS_T1_2000_NS));
  localparam gts_pkg::gts_cnt_t C1100 = 7'(`GTS_CYC(`GTS_T1_1100_NS));
  localparam gts_pkg::gts_cnt_t C500  = 7'(`GTS_CYC(`GTS_T1_500_NS));
  localparam gts_pkg::gts_cnt_t C350  = 7'(`GTS_CYC(`GTS_T1_350_NS));

  // T1 selection in both compatibility modes
  function automatic gts_pkg::gts_cnt_t t1_sel(input logic alt, input logic hs, input logic us,
                                               input logic tri_b, input logic vs, input logic st);
    gts_cnt_t_unused_guard: begin end
    if (!alt) begin
      if (!tri_b) t1_sel = C2000;
      else if (!hs) t1_sel = C1100;
      else if (us) t1_sel = C350;
      else t1_sel = C500;
    end else begin
      if (!us && !vs && !st) t1_sel = C2000;
      else if (!hs) t1_sel = st ? C1100 : C2000;
      else if (us) t1_sel = C350;
      else if (vs) t1_sel = C500;
      else t1_sel = C1100;
    end
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [3:0] s1_q, s2_q;
  logic [7:0] dio1_q, dio2_q;
  always_ff @(posedge CLK_IN) begin
    s1_q   <= {ATN_IN, DAV_IN, NDAC_IN, NRFD_IN};
    s2_q   <= s1_q;
    dio1_q <= DIO_IN;
    dio2_q <= dio1_q;
  end
  wire atn  = s2_q[3];
  wire dav  = s2_q[2];
  wire ndac = s2_q[1];
  wire nrfd = s2_q[0];

  // ==========================================================
  // Addressing state
  logic talk_q, lstn_q, ton_q, lon_q, cpt_q, hold_q, address_status_change_flag_q, dav_seen_q;
  logic [7:0] captured_command_register_q;
  wire talk_addr = dio2_q[6:5] == 2'b10 && dio2_q[4:0] != 5'h1F;
  wire lstn_addr = dio2_q[6:5] == 2'b01 && dio2_q[4:0] != 5'h1F;
  wire grp_cmd   = dio2_q[6:4] == 3'b000 || dio2_q[6:4] == 3'b001 || dio2_q[6:5] == 2'b11;
  wire hold_hit  = (HOLD_TALK_ADDR_IN && talk_addr) || (HOLD_LSTN_ADDR_IN && lstn_addr) ||
                   (HOLD_GROUP_IN && grp_cmd);
  wire cmd_new   = atn && dav && !dav_seen_q;
  wire address_mode_register_talk = ADDRESS_MODE_REGISTER_WR_IN && ADDRESS_MODE_REGISTER_DATA_IN == `GTS_ADDRESS_MODE_REGISTER_TALK_SET;
  wire address_mode_register_lstn = ADDRESS_MODE_REGISTER_WR_IN && ADDRESS_MODE_REGISTER_DATA_IN == `GTS_ADDRESS_MODE_REGISTER_LSTN_SET;
  wire talk_d    = address_mode_register_talk ? 1'b1 : talk_q;
  wire lstn_d    = address_mode_register_lstn ? 1'b1 : lstn_q;
  wire ton_d     = ADDRESS_MODE_REGISTER_WR_IN ? ADDRESS_MODE_REGISTER_DATA_IN == `GTS_ADDRESS_MODE_REGISTER_TON : ton_q;
  wire lon_d     = ADDRESS_MODE_REGISTER_WR_IN ? ADDRESS_MODE_REGISTER_DATA_IN == `GTS_ADDRESS_MODE_REGISTER_LON : lon_q;
  wire talker    = talk_q || ton_q;
  // Command capture and DAC holdoff
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cpt_q <= 1'b0; hold_q <= 1'b0; captured_command_register_q <= 8'h00; dav_seen_q <= 1'b0;
    end else begin
      dav_seen_q <= atn && dav;
      if (cmd_new && hold_hit) begin
        cpt_q <= 1'b1;
        hold_q <= 1'b1;
        captured_command_register_q <= dio2_q;
      end else begin
        if (CPT_CLR_IN) cpt_q <= 1'b0;
        if (VALID_CMD_IN) hold_q <= 1'b0;
      end
    end
  end
  // Address mode effects
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      talk_q <= 1'b0; lstn_q <= 1'b0; ton_q <= 1'b0; lon_q <= 1'b0; address_status_change_flag_q <= 1'b0;
    end else begin
      talk_q <= talk_d;
      lstn_q <= lstn_d;
      ton_q <= ton_d;
      lon_q <= lon_d;
      if (talk_d != talk_q || lstn_d != lstn_q || ton_d != ton_q || lon_d != lon_q) address_status_change_flag_q <= 1'b1;
      else if (ADDRESS_STATUS_CHANGE_FLAG_CLR_IN) address_status_change_flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // Output byte register and source handshake
  gts_pkg::gts_src_e st_q;
  gts_pkg::gts_cnt_t cnt_q;
  logic full_q, end_q, do_q, err_q, handshake_sequence_flag_q, end_pend_q;
  logic [7:0] output_byte_register_q;
  wire dma_wr    = DMA_OUT_EN_IN && !DMA_ACK_N_IN && !DMA_WR_N_IN;
  wire byte_wr   = OUTPUT_BYTE_REGISTER_WR_IN || dma_wr;
  wire [7:0] wdat = OUTPUT_BYTE_REGISTER_WR_IN ? OUTPUT_BYTE_REGISTER_DATA_IN : OUTPUT_BYTE_REGISTER_DATA_IN;
  wire listener  = ndac || nrfd;
  wire no_talk_without_listener      = AUX_G_IN[`GTS_AUXG_NO_TALK_WITHOUT_LISTENER_BIT];
  wire may_src   = talker && !atn && full_q && !(no_talk_without_listener && !listener);
  wire eos_hit   = AUX_A_IN[`GTS_AUXA_TRANSMIT_END_ON_MATCH_BIT] && output_byte_register_q == EOS_IN;
  wire gts_pkg::gts_cnt_t t1 = t1_sel(ALT_MODE_IN, handshake_sequence_flag_q, AUX_I_IN[`GTS_AUXI_ULTRA_SHORT_DELAY_BIT_BIT],
                                      AUX_B_IN[`GTS_AUXB_TRI_BIT], VSTD_IN, STD_IN);
  // Source state machine
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_q <= gts_pkg::GTS_IDLE; cnt_q <= 7'h00; full_q <= 1'b0; output_byte_register_q <= 8'h00;
      end_q <= 1'b0; end_pend_q <= 1'b0; do_q <= 1'b0; err_q <= 1'b0; handshake_sequence_flag_q <= 1'b0;
    end else begin
      if (SEND_END_CMD_IN) end_pend_q <= 1'b1;
      if (atn) handshake_sequence_flag_q <= 1'b0;
      if (CLEAR_ERR_CMD_IN) err_q <= 1'b0;
      if (byte_wr) begin
        output_byte_register_q <= wdat; full_q <= 1'b1; do_q <= 1'b0;
        end_q <= end_pend_q; end_pend_q <= 1'b0;
      end
      case (st_q)
        gts_pkg::GTS_IDLE: begin
          if (DISCARD_CMD_IN) full_q <= 1'b0;
          else if (talker && !atn && full_q && !listener) err_q <= 1'b1;
          if (may_src && !DISCARD_CMD_IN && !byte_wr) begin
            st_q <= gts_pkg::GTS_SETTLE; cnt_q <= t1;
          end else if (talker && !full_q && !byte_wr && !do_q) do_q <= 1'b1;
        end
        gts_pkg::GTS_SETTLE: begin
          if (atn) st_q <= gts_pkg::GTS_IDLE;
          else if (cnt_q <= 7'h01 && !nrfd) st_q <= gts_pkg::GTS_DAV;
          else if (cnt_q > 7'h01) cnt_q <= cnt_q - 7'h01;
        end
        gts_pkg::GTS_DAV: begin
          if (atn) st_q <= gts_pkg::GTS_IDLE;
          else if (!ndac) begin
            st_q <= gts_pkg::GTS_WAIT_NDAC;
            full_q <= 1'b0; do_q <= 1'b1; handshake_sequence_flag_q <= 1'b1;
          end
        end
        default: st_q <= gts_pkg::GTS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Settle time monitor for the T1 checks
  logic [7:0] settle_q;
  gts_pkg::gts_cnt_t t1_lat_q;
  // Cycles spent driving before DAV
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      settle_q <= 8'h00;
    end else if (st_q != gts_pkg::GTS_SETTLE) begin
      settle_q <= 8'h00;
    end else if (settle_q != 8'hFF) begin
      settle_q <= settle_q + 8'h01;
    end
  end
  // T1 loaded on the way out of idle
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      t1_lat_q <= 7'h00;
    end else if (st_q == gts_pkg::GTS_IDLE) begin
      t1_lat_q <= t1;
    end
  end

  // ==========================================================
  // Outputs
  wire driving = st_q == gts_pkg::GTS_SETTLE || st_q == gts_pkg::GTS_DAV;
  assign DIO_OUT        = output_byte_register_q;
  assign DIO_OE_OUT     = driving;
  assign DAV_OUT        = st_q == gts_pkg::GTS_DAV;
  assign EOI_OUT        = driving && (end_q || eos_hit);
  assign NDAC_HOLD_OUT  = hold_q;
  assign CAPTURED_COMMAND_REGISTER_OUT       = captured_command_register_q;
  assign CPT_OUT        = cpt_q;
  assign TALKER_OUT     = talker;
  assign LISTENER_OUT   = lstn_q || lon_q;
  assign ADDRESS_STATUS_CHANGE_FLAG_OUT       = address_status_change_flag_q;
  assign DO_OUT         = do_q;
  assign ERR_OUT        = err_q;
  assign BUS_STATUS_OUT = {ndac, nrfd};
  assign IRQ_OUT        = (DATA_OUT_IRQ_ENABLE_IN && do_q) || (ERROR_IRQ_ENABLE_IN && err_q);
  assign DMA_REQ_OUT    = DMA_OUT_EN_IN && talker && !full_q;
  assign HANDSHAKE_SEQUENCE_FLAG_OUT       = handshake_sequence_flag_q;

  // ==========================================================
  // Assertions
  hold_release_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    hold_q && !VALID_CMD_IN && !(cmd_new && hold_hit) |=> hold_q) else $error("holdoff dropped early");
  talk_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    address_mode_register_talk |=> talk_q) else $error("talker not set");
  dav_t1_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(DAV_OUT) |-> $past(DIO_OE_OUT, 2)) else $error("dav before settle");
  dma_req_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    DMA_REQ_OUT |-> !full_q) else $error("dma request while full");
  do_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    DAV_OUT && !ndac && !atn |=> DO_OUT) else $error("data out not set");
  irq_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !DATA_OUT_IRQ_ENABLE_IN && !ERROR_IRQ_ENABLE_IN |-> !IRQ_OUT) else $error("irq while masked");
  no_talk_without_listener_block_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    st_q == gts_pkg::GTS_IDLE && no_talk_without_listener && !listener |=> !DIO_OE_OUT) else $error("sourced with no listener");
  handshake_sequence_flag_clear_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    atn && !(st_q == gts_pkg::GTS_DAV) |=> !handshake_sequence_flag_q) else $error("sequence flag not cleared");
  cpt_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    cmd_new && hold_hit |=> cpt_q && hold_q) else $error("pass-through not raised");
  t1_wait_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(DAV_OUT) |-> settle_q >= {1'b0, t1_lat_q}) else $error("dav before T1 elapsed");
  t1_slow_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !ALT_MODE_IN && !AUX_B_IN[`GTS_AUXB_TRI_BIT] |-> t1 == C2000) else $error("slow T1 not selected");
  t1_fast_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !ALT_MODE_IN && AUX_B_IN[`GTS_AUXB_TRI_BIT] && AUX_I_IN[`GTS_AUXI_ULTRA_SHORT_DELAY_BIT_BIT] && handshake_sequence_flag_q |-> t1 == C350)
    else $error("fastest T1 not selected");
  alt_slow_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ALT_MODE_IN && !AUX_I_IN[`GTS_AUXI_ULTRA_SHORT_DELAY_BIT_BIT] && !VSTD_IN && !STD_IN |-> t1 == C2000)
    else $error("alternate slow T1 not selected");
  err_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    st_q == gts_pkg::GTS_IDLE && talker && !atn && full_q && !listener && !DISCARD_CMD_IN |=> ERR_OUT)
    else $error("error flag not set");
  pend_keep_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    driving && atn |=> st_q == gts_pkg::GTS_IDLE && full_q) else $error("pending byte lost under attention");
  discard_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    st_q == gts_pkg::GTS_IDLE && DISCARD_CMD_IN |=> !full_q) else $error("pending byte not discarded");
  address_status_change_flag_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    address_mode_register_talk && !talk_q |=> ADDRESS_STATUS_CHANGE_FLAG_OUT) else $error("address change not flagged");
  byte_sent_c: cover property (@(posedge CLK_IN) disable iff (RST_IN) $rose(DO_OUT));
  err_c: cover property (@(posedge CLK_IN) disable iff (RST_IN) $rose(ERR_OUT));
  hold_c: cover property (@(posedge CLK_IN) disable iff (RST_IN) $fell(hold_q));
  eoi_c: cover property (@(posedge CLK_IN) disable iff (RST_IN) $rose(EOI_OUT));
  dma_c: cover property (@(posedge CLK_IN) disable iff (RST_IN) dma_wr);
endmodule // gts_talker

// >>> gts_listener_model.sv
module gts_listener_model (
  // Clock, reset and presence
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       present_in,
  // Talker side of the bus
  input  wire logic       dav_in,
  input  wire logic       eoi_in,
  input  wire logic [7:0] dio_in,
  // Acceptor lines and captured byte
  output logic            ndac_out,
  output logic            nrfd_out,
  output logic      [7:0] byte_out,
  output logic            eoi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  // ====================
  // Acceptor handshake; absent listener leaves lines released
  always_ff @(posedge clk_in) begin
    if (rst_in || !present_in) begin
      ndac_out <= 1'h0;
      nrfd_out <= 1'h0;
      wait_q   <= 2'h0;
      byte_out <= 8'h00;
      eoi_out  <= 1'h0;
    end else if (!dav_in) begin
      ndac_out <= 1'h1;
      nrfd_out <= 1'h0;
      wait_q   <= 2'h0;
    end else if (wait_q != 2'h3) begin
      wait_q   <= wait_q + 2'h1;
      byte_out <= dio_in;
      eoi_out  <= eoi_in;
    end else begin
      ndac_out <= 1'h0;
      nrfd_out <= 1'h1;
    end
  end
endmodule // gts_listener_model

// >>> gts_talker_source_path_test.sv
module gts_talker_source_path_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Stimulus and observed signals
  logic CLK_IN, RST_IN, ADDRESS_MODE_REGISTER_WR_IN, HOLD_TALK_ADDR_IN, HOLD_LSTN_ADDR_IN, HOLD_GROUP_IN;
  logic ALT_MODE_IN, VSTD_IN, STD_IN, DATA_OUT_IRQ_ENABLE_IN, ERROR_IRQ_ENABLE_IN, DMA_OUT_EN_IN, VALID_CMD_IN;
  logic DISCARD_CMD_IN, CLEAR_ERR_CMD_IN, SEND_END_CMD_IN, ADDRESS_STATUS_CHANGE_FLAG_CLR_IN, CPT_CLR_IN, OUTPUT_BYTE_REGISTER_WR_IN;
  logic DMA_ACK_N_IN, DMA_WR_N_IN, ATN_IN, DAV_IN, NDAC_IN, NRFD_IN, present, eoi_seen;
  logic [7:0] ADDRESS_MODE_REGISTER_DATA_IN, AUX_G_IN, AUX_A_IN, AUX_B_IN, AUX_I_IN, EOS_IN, OUTPUT_BYTE_REGISTER_DATA_IN;
  logic [7:0] DIO_IN, DIO_OUT, CAPTURED_COMMAND_REGISTER_OUT, byte_seen;
  logic DIO_OE_OUT, DAV_OUT, EOI_OUT, NDAC_HOLD_OUT, CPT_OUT, TALKER_OUT, LISTENER_OUT;
  logic ADDRESS_STATUS_CHANGE_FLAG_OUT, DO_OUT, ERR_OUT, IRQ_OUT, DMA_REQ_OUT, HANDSHAKE_SEQUENCE_FLAG_OUT;
  logic [1:0] BUS_STATUS_OUT;
  int fails = 0;
  int samples_checked = 0;
  gts_talker gts_talker_i (.*);
  gts_listener_model gts_listener_model_i (.clk_in(CLK_IN), .rst_in(RST_IN), .present_in(present),
    .dav_in(DAV_OUT), .eoi_in(EOI_OUT), .dio_in(DIO_OUT), .ndac_out(NDAC_IN), .nrfd_out(NRFD_IN),
    .byte_out(byte_seen), .eoi_out(eoi_seen));
  // Clock at 50 MHz
  initial begin
    CLK_IN = 1'h0;
    forever #10 CLK_IN = ~CLK_IN;
  end
  // Cycle ceiling against a hang
  initial begin
    repeat (4000) @(posedge CLK_IN);
    fails++;
    wrap_up();
  end
  // ====================
  // Tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge CLK_IN);
    s = 1'h0;
    @(negedge CLK_IN);
  endtask
  task automatic address_mode_register(input logic [7:0] b);
    ADDRESS_MODE_REGISTER_DATA_IN = b;
    pulse(ADDRESS_MODE_REGISTER_WR_IN);
  endtask
  // One byte through host or DMA write, timed against T1 in cycles
  task automatic send(input logic [7:0] b, input int t1, input logic dma, input logic eoi);
    int n;
    OUTPUT_BYTE_REGISTER_DATA_IN = b;
    if (dma) {DMA_ACK_N_IN, DMA_WR_N_IN} = 2'h0;
    else OUTPUT_BYTE_REGISTER_WR_IN = 1'h1;
    @(negedge CLK_IN);
    {OUTPUT_BYTE_REGISTER_WR_IN, DMA_ACK_N_IN, DMA_WR_N_IN} = 3'h3;
    @(negedge CLK_IN);
    chk("do_clear", 8'h00, DO_OUT);
    if (dma) chk("dma_req", 8'h00, DMA_REQ_OUT);
    for (n = 2; n < 200 && DAV_OUT !== 1'h1; n++) @(negedge CLK_IN);
    chk("t1", 8'h01, 8'(n >= t1 && n <= t1 + 6));
    chk("dio", b, DIO_OUT);
    for (n = 0; n < 60 && DO_OUT !== 1'h1; n++) @(negedge CLK_IN);
    chk("do", 8'h01, DO_OUT);
    chk("byte", b, byte_seen);
    chk("end", 8'(eoi), eoi_seen);
    chk("handshake_sequence_flag", 8'h01, HANDSHAKE_SEQUENCE_FLAG_OUT);
  endtask
  // ====================
  // Main sequence
  initial begin
    {RST_IN, DMA_ACK_N_IN, DMA_WR_N_IN, present} = 4'hE;
    {ADDRESS_MODE_REGISTER_WR_IN, HOLD_TALK_ADDR_IN, HOLD_LSTN_ADDR_IN, HOLD_GROUP_IN, ALT_MODE_IN, VSTD_IN} = '0;
    {STD_IN, DATA_OUT_IRQ_ENABLE_IN, ERROR_IRQ_ENABLE_IN, DMA_OUT_EN_IN, VALID_CMD_IN, DISCARD_CMD_IN} = '0;
    {CLEAR_ERR_CMD_IN, SEND_END_CMD_IN, ADDRESS_STATUS_CHANGE_FLAG_CLR_IN, CPT_CLR_IN, OUTPUT_BYTE_REGISTER_WR_IN, ATN_IN, DAV_IN} = '0;
    {ADDRESS_MODE_REGISTER_DATA_IN, AUX_G_IN, AUX_A_IN, AUX_B_IN, AUX_I_IN, EOS_IN, OUTPUT_BYTE_REGISTER_DATA_IN, DIO_IN} = '0;
    repeat (6) @(negedge CLK_IN);
    RST_IN = 1'h0;
    chk("talker", 8'h00, TALKER_OUT);
    address_mode_register(8'h30);
    HOLD_TALK_ADDR_IN = 1'h1;
    {ATN_IN, DAV_IN, DIO_IN} = {2'h3, 8'h45};
    repeat (6) @(negedge CLK_IN);
    chk("cpt", 8'h01, CPT_OUT);
    chk("captured_command_register", 8'h45, CAPTURED_COMMAND_REGISTER_OUT);
    chk("hold", 8'h01, NDAC_HOLD_OUT);
    address_mode_register(8'hB0);
    address_mode_register(8'h30);
    chk("talker", 8'h01, TALKER_OUT);
    chk("address_status_change_flag", 8'h01, ADDRESS_STATUS_CHANGE_FLAG_OUT);
    pulse(VALID_CMD_IN);
    chk("hold", 8'h00, NDAC_HOLD_OUT);
    {ATN_IN, DAV_IN, DIO_IN, present} = {2'h0, 8'hBA, 1'h1};
    repeat (4) @(negedge CLK_IN);
    chk("bus", 8'h02, BUS_STATUS_OUT);
    AUX_G_IN = 8'h08;
    send(8'hA5, 100, 1'h0, 1'h0);
    {AUX_B_IN, AUX_I_IN} = 16'h0408;
    send(8'h3C, 18, 1'h0, 1'h0);
    pulse(SEND_END_CMD_IN);
    send(8'h11, 18, 1'h0, 1'h1);
    {AUX_A_IN, EOS_IN} = 16'h080D;
    send(8'h0D, 18, 1'h0, 1'h1);
    {AUX_A_IN, AUX_I_IN, ATN_IN} = 17'h00001;
    repeat (4) @(negedge CLK_IN);
    chk("handshake_sequence_flag", 8'h00, HANDSHAKE_SEQUENCE_FLAG_OUT);
    ATN_IN = 1'h0;
    send(8'h22, 55, 1'h0, 1'h0);
    DMA_OUT_EN_IN = 1'h1;
    @(negedge CLK_IN);
    chk("dma_req", 8'h01, DMA_REQ_OUT);
    send(8'h7E, 25, 1'h1, 1'h0);
    {DMA_OUT_EN_IN, ALT_MODE_IN, STD_IN, AUX_B_IN} = 11'h300;
    send(8'h5A, 55, 1'h0, 1'h0);
    {present, ERROR_IRQ_ENABLE_IN} = 2'h1;
    repeat (4) @(negedge CLK_IN);
    {OUTPUT_BYTE_REGISTER_DATA_IN, OUTPUT_BYTE_REGISTER_WR_IN} = {8'h55, 1'h1};
    @(negedge CLK_IN);
    OUTPUT_BYTE_REGISTER_WR_IN = 1'h0;
    repeat (12) @(negedge CLK_IN);
    chk("err", 8'h01, ERR_OUT);
    chk("dav", 8'h00, DAV_OUT);
    chk("irq", 8'h01, IRQ_OUT);
    pulse(DISCARD_CMD_IN);
    pulse(CLEAR_ERR_CMD_IN);
    chk("err", 8'h00, ERR_OUT);
    chk("irq", 8'h00, IRQ_OUT);
    DATA_OUT_IRQ_ENABLE_IN = 1'h1;
    repeat (2) @(negedge CLK_IN);
    chk("irq", 8'h01, IRQ_OUT);
    RST_IN = 1'h1;
    repeat (3) @(negedge CLK_IN);
    RST_IN = 1'h0;
    chk("talker", 8'h00, TALKER_OUT);
    address_mode_register(8'h40);
    chk("listener", 8'h01, LISTENER_OUT);
    wrap_up();
  end
endmodule // gts_talker_source_path_test
